// file: core/emp_consts.svh
// constants for the encoder multiturn and divided pulse output block
// assumes inclusion by bare name from core files
`ifndef EMP_CONSTS_SVH
`define EMP_CONSTS_SVH
`define EMP_REG_WRAP_LIMIT 16'h30A9
`define EMP_REG_DIVIDER 16'h30AA
`define EMP_REG_CONFIG 16'h30AB
`define EMP_REG_STATUS 16'h30AC
`define EMP_WRAP_RESET 16'h000A
`define EMP_DIV_RESET 16'h4000
`define EMP_DIV_MIN 16'h0010
`define EMP_DIV_MAX 16'h4000
`define EMP_USE_ABS 1'b0
`define EMP_USE_INC 1'b1
`define EMP_CFG_USAGE 0
`define EMP_CFG_DIR 1
`define EMP_CFG_SINGLE 2
`endif

// file: core/emp_pkg.sv
// types shared by the encoder multiturn and pulse output block
// assumes emp_consts.svh beside it
package emp_pkg;
   typedef struct packed {
      logic usage;
      logic dirRev;
      logic singleTurn;
   } emp_cfg_t;
   typedef struct packed {
      logic phaseA;
      logic phaseB;
      logic phaseC;
   } emp_pulse_t;
   typedef enum logic [1:0] {EMP_Q0, EMP_Q1, EMP_Q2, EMP_Q3} emp_quad_t;
endpackage : emp_pkg

// file: core/emp_quad_gen.sv
// quadrature stepper: one step per request, gray sequence over four states
// assumes step requests are single-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module emp_quad_gen
   import emp_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic stepFwd,
   input wire logic stepRev,
   output logic phaseA,
   output logic phaseB
);
   emp_quad_t state;
   emp_quad_t next_state;
   always_comb begin
      next_state = state;
      if (stepFwd && !stepRev) begin
         case (state)
            EMP_Q0: next_state = EMP_Q1;
            EMP_Q1: next_state = EMP_Q2;
            EMP_Q2: next_state = EMP_Q3;
            EMP_Q3: next_state = EMP_Q0;
            default: next_state = EMP_Q0;
         endcase
      end else if (stepRev && !stepFwd) begin
         case (state)
            EMP_Q0: next_state = EMP_Q3;
            EMP_Q1: next_state = EMP_Q0;
            EMP_Q2: next_state = EMP_Q1;
            EMP_Q3: next_state = EMP_Q2;
            default: next_state = EMP_Q0;
         endcase
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= EMP_Q0;
         phaseA <= 1'b0;
         phaseB <= 1'b0;
      end else begin
         state <= next_state;
         // A leads B going up the sequence, 90 degrees apart
         phaseA <= (next_state == EMP_Q1) || (next_state == EMP_Q2);
         phaseB <= (next_state == EMP_Q2) || (next_state == EMP_Q3);
      end
   end
endmodule : emp_quad_gen
`default_nettype wire

// file: core/emp_encoder_out.sv
// encoder use selection, multiturn counter and divided pulse output
// assumes encoder counts arrive as single-cycle step pulses, a revolution
// mark pulses at the forward or reverse crossing, and restart is the
// restart input or the reset; settings are written by register port
`include "emp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module emp_encoder_out
   import emp_pkg::*;
#(
   parameter int ENC_RES = 16384
)
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic restart,
   input wire logic encStepFwd,
   input wire logic encStepRev,
   input wire logic encIndex,
   input wire logic revFwd,
   input wire logic revRev,
   input wire logic encIsIncremental,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [15:0] regAddr,
   input wire logic [15:0] regWdata,
   output logic [15:0] regRdata,
   output logic regAck,
   output logic [15:0] multiturnCount,
   output logic absEncoderAlarmFirst,
   output logic absEncoderAlarmSecond,
   output emp_pulse_t dividedOut
);
   // ==========================================================
   // elaboration checks
   if (ENC_RES < 16 || ENC_RES > 65535) begin : g_bad_res
      $error("emp_encoder_out: encoder resolution out of range");
   end

   // ==========================================================
   // register port
   logic [15:0] wrapLimit;
   logic [15:0] divider;
   emp_cfg_t cfg;
   logic [15:0] activeLimit;
   logic [15:0] activeDiv;
   emp_cfg_t activeCfg;
   logic firstPowerUp;
   wire logic hitLimit = regAddr == `EMP_REG_WRAP_LIMIT;
   wire logic hitDiv = regAddr == `EMP_REG_DIVIDER;
   wire logic hitCfg = regAddr == `EMP_REG_CONFIG;
   wire logic hitStat = regAddr == `EMP_REG_STATUS;
   // out-of-range divider writes are dropped so the divider stays legal
   wire logic divLegal = (regWdata >= `EMP_DIV_MIN)
      && (regWdata <= `EMP_DIV_MAX);
   wire logic [15:0] statusWord = {13'h0000, absEncoderAlarmSecond,
      absEncoderAlarmFirst, activeCfg.usage};
   wire logic [15:0] next_rdata = hitLimit ? wrapLimit
      : hitDiv ? divider
      : hitCfg ? {13'h0000, cfg.singleTurn, cfg.dirRev, cfg.usage}
      : hitStat ? statusWord : 16'h0000;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wrapLimit <= `EMP_WRAP_RESET;
         divider <= `EMP_DIV_RESET;
         cfg <= '0;
      end else if (regWrite) begin
         if (hitLimit)
            wrapLimit <= regWdata;
         if (hitDiv && divLegal)
            divider <= regWdata;
         // bit order must match the read-back word
         if (hitCfg) begin
            cfg.usage <= regWdata[`EMP_CFG_USAGE];
            cfg.dirRev <= regWdata[`EMP_CFG_DIR];
            cfg.singleTurn <= regWdata[`EMP_CFG_SINGLE];
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         regRdata <= 16'h0000;
         regAck <= 1'b0;
      end else begin
         regAck <= regRead || regWrite;
         if (regRead)
            regRdata <= next_rdata;
      end
   end

   // ==========================================================
   // settings taken over only at restart
   logic pendLoad;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pendLoad <= 1'b1;
         activeLimit <= `EMP_WRAP_RESET;
         activeDiv <= `EMP_DIV_RESET;
         activeCfg <= '0;
      end else begin
         pendLoad <= restart;
         if (pendLoad) begin
            activeLimit <= wrapLimit;
            activeDiv <= divider;
            activeCfg <= cfg;
         end
      end
   end

   // ==========================================================
   // encoder alarm at first power-up
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         firstPowerUp <= 1'b1;
         absEncoderAlarmFirst <= 1'b0;
         absEncoderAlarmSecond <= 1'b0;
      end else begin
         firstPowerUp <= 1'b0;
         // sticky until the next reset; two codes for one cause
         if (firstPowerUp && encIsIncremental
               && cfg.usage == `EMP_USE_ABS) begin
            absEncoderAlarmFirst <= 1'b1;
            absEncoderAlarmSecond <= 1'b1;
         end
      end
   end

   // ==========================================================
   // multiturn counter
   wire logic holdZero = activeCfg.singleTurn
      || activeCfg.usage == `EMP_USE_INC;
   // the default limit counts freely over the full span
   wire logic wrapActive = activeCfg.usage == `EMP_USE_ABS
      && activeLimit != `EMP_WRAP_RESET;
   wire logic [15:0] limMinus = activeLimit - 16'h0001;
   logic [15:0] next_count;
   always_comb begin
      next_count = multiturnCount;
      if (holdZero)
         next_count = 16'h0000;
      else if (revFwd && !revRev) begin
         if (wrapActive && multiturnCount == limMinus)
            next_count = 16'h0000;
         else
            next_count = multiturnCount + 16'h0001;
      end else if (revRev && !revFwd) begin
         if (wrapActive && multiturnCount == 16'h0000)
            next_count = limMinus;
         else
            next_count = multiturnCount - 16'h0001;
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         multiturnCount <= 16'h0000;
      else
         multiturnCount <= next_count;
   end

   // ==========================================================
   // rate divider: accumulate divider per encoder count, step on overflow
   // divider must not exceed ENC_RES; the configurer keeps to it
   localparam logic [16:0] RES = 17'(ENC_RES);
   logic [16:0] acc;
   logic [16:0] next_acc;
   logic outFwd;
   logic outRev;
   wire logic [16:0] div17 = {1'b0, activeDiv};
   // direction setting deliberately ignored here
   wire logic dirUp = encStepFwd && !encStepRev;
   wire logic dirDn = encStepRev && !encStepFwd;
   always_comb begin
      next_acc = acc;
      outFwd = 1'b0;
      outRev = 1'b0;
      if (dirUp) begin
         if (acc + div17 >= RES) begin
            next_acc = acc + div17 - RES;
            outFwd = 1'b1;
         end else
            next_acc = acc + div17;
      end else if (dirDn) begin
         if (acc < div17) begin
            next_acc = acc + RES - div17;
            outRev = 1'b1;
         end else
            next_acc = acc - div17;
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         acc <= 17'h00000;
      else
         acc <= next_acc;
   end

   // four quadrature edges form one output pulse; the stepper moves one edge per overflow
   logic stepA;
   logic stepB;
   emp_quad_gen u_emp_quad_gen (
      .clock(clock),
      .arst_n(arst_n),
      .stepFwd(outFwd),
      .stepRev(outRev),
      .phaseA(stepA),
      .phaseB(stepB)
   );

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         dividedOut.phaseC <= 1'b0;
      else
         dividedOut.phaseC <= encIndex;
   end
   assign dividedOut.phaseA = stepA;
   assign dividedOut.phaseB = stepB;
endmodule : emp_encoder_out
`default_nettype wire

// file: tb/emp_encoder_out_monitor.sv
// checker for the encoder multiturn and divided pulse output block
// assumes it is bound onto emp_encoder_out
`timescale 1ns/1ps
`default_nettype none
module emp_encoder_out_monitor
   import emp_pkg::*;
#(
   parameter int ENC_RES = 16384
)
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic encStepFwd,
   input wire logic encStepRev,
   input wire logic encIndex,
   input wire logic revFwd,
   input wire logic revRev,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic regAck,
   input wire logic [15:0] multiturnCount,
   input wire logic absEncoderAlarmFirst,
   input wire logic absEncoderAlarmSecond,
   input wire emp_pulse_t dividedOut
);
   // ==========================================
   // properties
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire logic [1:0] ab = {dividedOut.phaseA, dividedOut.phaseB};
   property p_ack; regWrite || regRead |=> regAck; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_index; 1'b1 |=> dividedOut.phaseC == $past(encIndex); endproperty
   a_index: assert property (p_index) else $error("index");
   property p_gray; $changed(ab) |-> ^(ab ^ $past(ab)); endproperty
   a_gray: assert property (p_gray) else $error("both phases moved");
   property p_fwd;
      $past(encStepFwd) && $changed(ab) |->
         ab == {~$past(ab[0]), $past(ab[1])};
   endproperty
   a_fwd: assert property (p_fwd) else $error("fwd order");
   property p_rev;
      $past(encStepRev) && $changed(ab) |->
         ab == {$past(ab[0]), ~$past(ab[1])};
   endproperty
   a_rev: assert property (p_rev) else $error("rev order");
   property p_alarm; absEncoderAlarmFirst == absEncoderAlarmSecond; endproperty
   a_alarm: assert property (p_alarm) else $error("alarm pair");
   property p_up;
      revFwd && !revRev && multiturnCount != 16'h0000 |=>
         multiturnCount == $past(multiturnCount) + 16'h0001 ||
         multiturnCount == 16'h0000;
   endproperty
   a_up: assert property (p_up) else $error("count up");
   property p_dn;
      revRev && !revFwd && multiturnCount != 16'h0000 |=>
         multiturnCount == $past(multiturnCount) - 16'h0001;
   endproperty
   a_dn: assert property (p_dn) else $error("count down");
   c_wrap: cover property (revRev && multiturnCount == 16'h0000);
   c_alarm: cover property ($rose(absEncoderAlarmFirst));
   c_index: cover property ($rose(dividedOut.phaseC));
endmodule : emp_encoder_out_monitor
bind emp_encoder_out emp_encoder_out_monitor #(.ENC_RES(ENC_RES))
   u_emp_encoder_out_monitor (
   .clock, .arst_n, .encStepFwd, .encStepRev, .encIndex, .revFwd, .revRev,
   .regWrite, .regRead, .regAck, .multiturnCount, .absEncoderAlarmFirst,
   .absEncoderAlarmSecond, .dividedOut);
`default_nettype wire

// file: tb/emp_host_model.sv
// host controller model: decodes the divided quadrature into a position
// assumes it samples the pulses on the drive clock
`timescale 1ns/1ps
`default_nettype none
module emp_host_model
   import emp_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire emp_pulse_t pulses,
   output logic signed [15:0] pos,
   output logic [15:0] skips
);
   logic [1:0] last;
   wire logic [1:0] now = {pulses.phaseA, pulses.phaseB};
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         last <= 2'h0;
         pos <= 16'sh0000;
         skips <= 16'h0000;
      end else begin
         last <= now;
         if (now == {~last[0], last[1]}) begin
            pos <= pos + 16'sh0001;
         end else if (now == {last[0], ~last[1]}) begin
            pos <= pos - 16'sh0001;
         end else if (now != last) begin
            // both edges at once cannot be decoded
            skips <= skips + 16'h0001;
         end
      end
   end
endmodule : emp_host_model
`default_nettype wire

// file: tb/emp_encoder_out_bench.sv
// bench for emp_encoder_out with a host decoder on the pulse outputs
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
`default_nettype none
`include "emp_consts.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   badCount++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module emp_encoder_out_bench
   import emp_pkg::*;
;
   // short count basis keeps one revolution brief
   localparam int RES = 64;
   logic clock, arst_n, restart, encStepFwd, encStepRev, encIndex;
   logic revFwd, revRev, encIsIncremental, regWrite, regRead;
   logic [15:0] regAddr, regWdata;
   wire logic [15:0] regRdata, multiturnCount, skips;
   wire logic regAck, absEncoderAlarmFirst, absEncoderAlarmSecond;
   wire logic signed [15:0] pos;
   wire emp_pulse_t dividedOut;
   int badCount = 0;
   int compares = 0;
   emp_encoder_out #(.ENC_RES(RES)) u_emp_encoder_out (.clock, .arst_n,
      .restart, .encStepFwd, .encStepRev, .encIndex, .revFwd, .revRev,
      .encIsIncremental, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
      .regAck, .multiturnCount, .absEncoderAlarmFirst, .absEncoderAlarmSecond,
      .dividedOut);
   emp_host_model u_emp_host_model (.clock, .arst_n, .pulses(dividedOut),
      .pos, .skips);
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // ==========================================
   // bus and stimulus helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      cyc(1);
      regWrite = 1'b0;
      cyc(1);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      regAddr = a;
      regRead = 1'b1;
      cyc(1);
      `CHK("ack", 1'b1, regAck)
      `CHK("rdata", e, regRdata)
      regRead = 1'b0;
      cyc(1);
   endtask : rd
   task automatic go();
      restart = 1'b1;
      cyc(1);
      restart = 1'b0;
      cyc(3);
   endtask : go
   task automatic turn(input logic f, input logic [15:0] e);
      revFwd = f;
      revRev = ~f;
      cyc(1);
      revFwd = 1'b0;
      revRev = 1'b0;
      `CHK("count", e, multiturnCount)
      cyc(1);
   endtask : turn
   task automatic steps(input int n, input logic f);
      repeat (n) begin
         encStepFwd = f;
         encStepRev = ~f;
         cyc(1);
         encStepFwd = 1'b0;
         encStepRev = 1'b0;
         cyc(1);
      end
      cyc(2);
   endtask : steps
   // ==========================================
   // scenarios
   task automatic t_regs();
      rd(`EMP_REG_WRAP_LIMIT, `EMP_WRAP_RESET);
      rd(`EMP_REG_CONFIG, 16'h0000);
      rd(`EMP_REG_STATUS, 16'h0000);
      rd(16'h3000, 16'h0000);
      wr(`EMP_REG_DIVIDER, 16'h000F);
      wr(`EMP_REG_DIVIDER, 16'h4001);
      rd(`EMP_REG_DIVIDER, `EMP_DIV_RESET);
      $display("test regs done");
   endtask : t_regs
   task automatic t_wrap();
      // default limit: the count runs over the full span, no wrap
      turn(1'b0, 16'hFFFF);
      turn(1'b1, 16'h0000);
      wr(`EMP_REG_WRAP_LIMIT, 16'h0003);
      go();
      turn(1'b0, 16'h0002);
      turn(1'b0, 16'h0001);
      turn(1'b1, 16'h0002);
      turn(1'b1, 16'h0000);
      $display("test wrap done");
   endtask : t_wrap
   task automatic t_pulses();
      logic signed [15:0] p0;
      wr(`EMP_REG_DIVIDER, `EMP_DIV_MIN);
      wr(`EMP_REG_CONFIG, 16'h0002);
      go();
      p0 = pos;
      steps(4 * RES, 1'b1);
      `CHK("fwd pulses", p0 + 16'sh0040, pos)
      steps(4 * RES, 1'b0);
      `CHK("rev pulses", p0, pos)
      `CHK("skips", 16'h0000, skips)
      encIndex = 1'b1;
      cyc(1);
      `CHK("index", 1'b1, dividedOut.phaseC)
      encIndex = 1'b0;
      cyc(1);
      `CHK("index", 1'b0, dividedOut.phaseC)
      $display("test pulses done");
   endtask : t_pulses
   task automatic t_modes();
      wr(`EMP_REG_CONFIG, 16'h0004);
      go();
      turn(1'b0, 16'h0000);
      wr(`EMP_REG_CONFIG, 16'h0001);
      go();
      turn(1'b0, 16'h0000);
      rd(`EMP_REG_STATUS, 16'h0001);
      $display("test modes done");
   endtask : t_modes
   task automatic t_alarm();
      encIsIncremental = 1'b1;
      arst_n = 1'b0;
      cyc(2);
      arst_n = 1'b1;
      cyc(2);
      `CHK("alarm1", 1'b1, absEncoderAlarmFirst)
      rd(`EMP_REG_STATUS, 16'h0006);
      $display("test alarm done");
   endtask : t_alarm
   task automatic tallyAndFinish();
      $display("compares %0d mismatches %0d", compares, badCount);
      if (badCount == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tallyAndFinish
   initial begin
      {arst_n, restart, encStepFwd, encStepRev, encIndex} = 5'h00;
      {revFwd, revRev, encIsIncremental, regWrite, regRead} = 5'h00;
      regAddr = 16'h0000;
      regWdata = 16'h0000;
      cyc(16);
      arst_n = 1'b1;
      cyc(2);
      t_regs();
      t_wrap();
      t_pulses();
      t_modes();
      t_alarm();
      tallyAndFinish();
   end
   initial begin
      #100000;
      badCount++;
      tallyAndFinish();
   end
endmodule : emp_encoder_out_bench
`default_nettype wire
